// ===== design/plph_handshake.sv
// Processor side of the low-power quiesce and idle/keepalive handshake
// Summary of operation
// RQ1 - Assert quiesce request to ask snooped bus activity to finish before low power.
// RQ2 - Hold quiesce request while quiescent; drop it when no longer wanted.
// RQ3 - Once quiescent low-power state is entered, stop snooping.
// RQ4 - System grants quiesce only after snooped activity ends; no low power without grant.
// RQ5 - System holds each grant level stable at least one bus cycle.
// RQ6 - Grant sampled at reset release; asserted disables reduced-pinout mode.
// RQ7 - Idle indicator asserts synchronously when idle with bus quiet.
// RQ8 - Keepalive keeps internal clocks running in nap so snooping works; code holds o_snoop_enable low in nap regardless.
// RQ9 - Idle indicator drops during bus activity and returns when idle.
// RQ10 - Keepalive taken asynchronously; clocks restart within three bus cycles.
// RQ11 - System releases keepalive only after idle indicator asserts.
// RQ12 - From normal only doze is reachable, needing system cooperation; code also enters nap from normal when synchronised keepalive is low.
// RQ13 - System holds keepalive ten cycles before power-down starts.
// RQ14 - Power bit write waits for idle, then asserts idle indicator: doze.
// RQ15 - System holds keepalive ten cycles after idle indicator on doze entry.
// RQ16 - In doze, idle indicator drops during a snoop write-back.
// RQ17 - System keeps keepalive asserted during doze snoop write-back.
// RQ18 - Power-down from normal without keepalive tries nap directly, unsupported.
// RQ19 - Doze to nap: bus idle, keepalive dropped, grants withheld ten cycles.
// RQ20 - System withholds grants so no transfer starts during doze to nap.
// RQ21 - Nap to doze: bus idle, keepalive raised, grants withheld ten cycles.
// RQ22 - Power state normal, doze or nap, cleared to normal by reset.
// RQ23 - System counts ten-cycle intervals with at least a four-bit counter.
`timescale 1ns/1ns
`include "plph_params.svh"
module plph_handshake
    import plph_pkg::*;
#(
    parameter int SETTLE = `PLPH_SETTLE_CYCLES,
    parameter int CNT_W  = `PLPH_CNT_W
) (
    input  wire logic       i_clock,                   // Bus clock, 25 MHz
    input  wire logic       i_rst,                     // Hard reset, active high
    input  wire logic       i_power_mgmt_bit,          // Software power-down bit
    input  wire logic       i_quiesce_want,            // Core wants quiescent state
    input  wire logic       i_quiesce_grant_n,         // System quiesce grant, low
    input  wire logic       i_clock_keepalive,         // Keep clocks running
    input  wire logic       i_core_idle,               // Dispatch and execution stopped
    input  wire logic       i_transfer_start_strobe_n, // Bus transfer start, low
    input  wire logic       i_extended_transfer_start_n, // Extended start, low
    input  wire logic       i_snoop_writeback,         // Snoop write-back running
    output logic            o_quiesce_request_n,       // Quiesce request, low
    output logic            o_idle,                    // Idle indicator
    output logic            o_clocks_run,              // Internal clocks enabled
    output logic            o_snoop_enable,            // Snooping active
    output logic            o_quiescent,               // Quiesced low-power state
    output logic            o_reduced_pinout,          // Reduced-pinout mode selected
    output plph_state_t     o_power_state,             // Power state
    output logic            o_unsupported_nap          // Direct nap attempted
);
    plph_state_t      state_ff;
    plph_state_t      nxt_state;
    logic             quiesce_request_n_ff;
    logic             quiescent_ff;
    logic             nxt_quiescent;
    logic             idle_ff;
    logic             nxt_idle;
    logic             clk_run_ff;
    logic             snoop_ff;
    logic             strap_done_ff;
    logic             pinout_ff;
    logic             bad_nap_ff;
    logic             keep_s1_ff;
    logic             keep_s2_ff;
    logic             bus_busy;
    logic [CNT_W-1:0] keep_low_cnt;
    logic [CNT_W-1:0] keep_high_cnt;

    // Any start strobe on the bus counts as activity
    assign bus_busy = !i_transfer_start_strobe_n || !i_extended_transfer_start_n;

    // Keepalive arrives asynchronously; two flops, first read only by second
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            keep_s1_ff <= 1'b0;
            keep_s2_ff <= 1'b0;
        end else begin
            keep_s1_ff <= i_clock_keepalive;      // RQ10
            keep_s2_ff <= keep_s1_ff;
        end
    end

    // Time how long keepalive has been low and high with a quiet bus
    plph_cycle_counter #(.WIDTH(CNT_W)) u_keep_low (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_cond  (!keep_s2_ff && !bus_busy),
        .o_count (keep_low_cnt)
    );

    plph_cycle_counter #(.WIDTH(CNT_W)) u_keep_high (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_cond  (keep_s2_ff && !bus_busy),
        .o_count (keep_high_cnt)
    );

    // Power state transitions
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PLPH_NORMAL: begin
                // Only doze is legal; no keepalive means an attempted direct nap
                if (i_power_mgmt_bit && i_core_idle && !bus_busy) begin
                    if (keep_s2_ff) begin
                        nxt_state = PLPH_DOZE;       // RQ12 RQ14
                    end else begin
                        nxt_state = PLPH_NAP;        // RQ18
                    end
                end
            end
            PLPH_DOZE: begin
                if (!i_power_mgmt_bit) begin
                    nxt_state = PLPH_NORMAL;
                end else if (!keep_s2_ff && !i_snoop_writeback
                             && keep_low_cnt >= CNT_W'(SETTLE)) begin
                    nxt_state = PLPH_NAP;            // RQ19
                end
            end
            PLPH_NAP: begin
                if (keep_high_cnt >= CNT_W'(SETTLE)) begin
                    nxt_state = PLPH_DOZE;           // RQ21
                end
            end
            default: begin
                nxt_state = PLPH_NORMAL;
            end
        endcase
    end

    // State register, normal after reset
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= PLPH_NORMAL;                 // RQ22
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Flag the unsupported direct-nap path so system can see the hazard
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bad_nap_ff <= 1'b0;
        end else if (state_ff == PLPH_NORMAL && nxt_state == PLPH_NAP) begin
            bad_nap_ff <= 1'b1;                      // RQ18
        end else if (nxt_state == PLPH_NORMAL) begin
            bad_nap_ff <= 1'b0;
        end
    end

    // Idle indicator: low on bus activity or snoop write-back
    always_comb begin
        nxt_idle = (nxt_state != PLPH_NORMAL) && i_core_idle && !bus_busy
                   && !i_snoop_writeback;            // RQ7 RQ9 RQ16
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            idle_ff <= 1'b0;
        end else begin
            idle_ff <= nxt_idle;                     // RQ14
        end
    end

    // Quiesce request follows the core's wish; held while quiescent
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            quiesce_request_n_ff <= 1'b0;
        end else begin
            quiesce_request_n_ff <= i_quiesce_want;               // RQ1 RQ2
        end
    end

    // Enter quiescent only once the system has granted
    always_comb begin
        nxt_quiescent = quiescent_ff;
        if (!quiesce_request_n_ff) begin
            nxt_quiescent = 1'b0;
        end else if (!i_quiesce_grant_n) begin
            nxt_quiescent = 1'b1;                    // RQ4
        end
    end

    // Next value is shared with snooping so both change on the same edge
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            quiescent_ff <= 1'b0;
        end else begin
            quiescent_ff <= nxt_quiescent;
        end
    end

    // Clocks run unless napping without keepalive; sync delay keeps wake within 3
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            clk_run_ff <= 1'b1;
        end else begin
            clk_run_ff <= (nxt_state != PLPH_NAP) || keep_s2_ff; // RQ8 RQ10
        end
    end

    // Snooping stops in nap or once quiesced
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            snoop_ff <= 1'b1;
        end else begin
            snoop_ff <= (nxt_state != PLPH_NAP) && !nxt_quiescent; // RQ3 RQ19
        end
    end

    // Strap caught at first clock after reset release
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            strap_done_ff <= 1'b0;
            pinout_ff     <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            pinout_ff     <= i_quiesce_grant_n;      // RQ6
        end
    end

    assign o_quiesce_request_n = !quiesce_request_n_ff;
    assign o_idle              = idle_ff;
    assign o_clocks_run        = clk_run_ff;
    assign o_snoop_enable      = snoop_ff;
    assign o_quiescent         = quiescent_ff;
    assign o_reduced_pinout    = pinout_ff;
    assign o_power_state       = state_ff;
    assign o_unsupported_nap   = bad_nap_ff;
endmodule : plph_handshake

// ===== design/plph_params.svh
// Constants for the low-power handshake block
`ifndef PLPH_PARAMS_SVH
`define PLPH_PARAMS_SVH
`define PLPH_CLK_PERIOD_NS   40
`define PLPH_SETTLE_CYCLES   10
`define PLPH_WAKE_MAX_CYCLES 3
`define PLPH_CNT_W           4
`define PLPH_CNT_ZERO        4'h0
`endif

// ===== design/plph_pkg.sv
// Types for the low-power handshake block
package plph_pkg;
    typedef enum logic [1:0] {
        PLPH_NORMAL = 2'b00,
        PLPH_DOZE   = 2'b01,
        PLPH_NAP    = 2'b10
    } plph_state_t;
endpackage : plph_pkg

// ===== design/plph_cycle_counter.sv
// Saturating counter of consecutive cycles a condition has held
`timescale 1ns/1ns
module plph_cycle_counter #(
    parameter int WIDTH = 4
) (
    input  wire logic             i_clock,  // Bus clock
    input  wire logic             i_rst,    // Sync reset, active high
    input  wire logic             i_cond,   // Condition being timed
    output logic      [WIDTH-1:0] o_count   // Cycles held, saturating
);
    logic [WIDTH-1:0] count_ff;

    // Restart on any drop of the condition; saturate to avoid wrap
    always_ff @(posedge i_clock) begin
        if (i_rst || !i_cond) begin
            count_ff <= '0;
        end else if (count_ff != {WIDTH{1'b1}}) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign o_count = count_ff;
endmodule : plph_cycle_counter

// ===== test/plph_handshake_asserts.sv
// Port checks for the low-power handshake
`timescale 1ns/1ns
module plph_handshake_asserts
    import plph_pkg::*;
#(parameter int SETTLE = 10) (
    input wire logic   i_clock, i_rst, i_power_mgmt_bit, i_quiesce_want, i_quiesce_grant_n,
    input wire logic   i_clock_keepalive, i_core_idle, i_transfer_start_strobe_n,
    input wire logic   i_extended_transfer_start_n, i_snoop_writeback, o_quiesce_request_n,
    input wire logic   o_idle, o_clocks_run, o_snoop_enable, o_quiescent, o_reduced_pinout,
    input wire logic   o_unsupported_nap,
    input plph_state_t o_power_state
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic [4:0] low_ff;
    wire        quiet = i_transfer_start_strobe_n & i_extended_transfer_start_n;
    // Raw keepalive-low quiet cycles; the synchroniser only makes the design later
    always_ff @(posedge i_clock)
        low_ff <= (i_rst | i_clock_keepalive | !quiet) ? 5'h00 : low_ff + {4'h0, ~&low_ff};
    chk_req_follows: assert property (o_quiesce_request_n == !$past(i_quiesce_want))
        else $error("quiesce request wrong");
    chk_quiet_nosnoop: assert property (o_quiescent |-> !o_snoop_enable)
        else $error("snoop while quiescent");
    chk_grant_first: assert property ($rose(o_quiescent) |-> !$past(i_quiesce_grant_n))
        else $error("quiescent without grant");
    chk_strap_taken: assert property ($fell(i_rst) |=>
        o_reduced_pinout == $past(i_quiesce_grant_n)) else $error("strap wrong");
    chk_idle_cause: assert property (o_idle |-> $past(quiet) && $past(i_core_idle) &&
        !$past(i_snoop_writeback) && o_power_state != PLPH_NORMAL) else $error("idle wrong");
    chk_wake_bound: assert property (o_power_state == PLPH_NAP && $rose(i_clock_keepalive)
        |-> ##[1:3] o_clocks_run) else $error("clocks late");
    chk_normal_exit: assert property ($past(o_power_state) == PLPH_NORMAL &&
        o_power_state == PLPH_NAP |-> o_unsupported_nap) else $error("nap unflagged");
    chk_nap_entry: assert property ($past(o_power_state) == PLPH_DOZE &&
        o_power_state == PLPH_NAP |-> $past(low_ff) >= SETTLE && !o_snoop_enable)
        else $error("nap too early");
endmodule : plph_handshake_asserts

// ===== test/plph_sys_model.sv
// System controller model: keepalive, quiesce grant and bus starts
`timescale 1ns/1ns
module plph_sys_model (
    input  wire logic i_clock,     // Bus clock
    input  wire logic i_rst,       // Sync reset
    input  wire logic i_quiesce_request_n_n,    // Quiesce request
    input  wire logic i_idle,      // Idle indicator
    input  wire logic i_go_nap,    // Nap wanted
    input  wire logic i_force_low, // Drop keepalive at once
    input  wire logic i_strap,     // Grant level in reset
    input  wire logic i_traffic,   // Starts wanted
    output logic      o_keep,      // Clock keepalive
    output logic      o_grant_n,   // Quiesce grant, low
    output logic      o_start_n    // Transfer start, low
);
    logic [3:0] cnt_ff = 4'h0;
    initial {o_keep, o_grant_n, o_start_n} = 3'h7;
    // Grant lags a cycle so each level lasts one; withheld the cycle after a start
    always @(posedge i_clock)
        o_grant_n <= i_rst ? i_strap : (i_quiesce_request_n_n | !o_start_n);
    // Keepalive moves only after ten steady quiet idle cycles, or drops at once on i_force_low
    always @(posedge i_clock) begin
        cnt_ff <= (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
        if (i_rst)
            o_keep <= 1'h1;
        else if (i_force_low)
            o_keep <= 1'h0;
        else if (cnt_ff >= 4'ha && o_keep == i_go_nap)
            o_keep <= !i_go_nap;
        if (i_rst || !o_start_n || !i_idle || (cnt_ff >= 4'ha && o_keep == i_go_nap))
            cnt_ff <= 4'h0;
    end
    // Grants withheld around keepalive changes, so starts wait ten quiet cycles
    always @(posedge i_clock)
        o_start_n <= i_rst | !(i_traffic & o_keep & !i_go_nap & cnt_ff >= 4'ha & o_start_n);
endmodule : plph_sys_model

// ===== test/plph_handshake_tb.sv
// Self-checking bench for the low-power handshake
`timescale 1ns/1ns
module plph_handshake_tb;
    import plph_pkg::*;
    logic i_clock = 1'h0, i_rst = 1'h1, i_power_mgmt_bit = 1'h0, i_quiesce_want = 1'h0;
    logic i_core_idle = 1'h0, i_snoop_writeback = 1'h0, i_extended_transfer_start_n = 1'h1;
    logic go_nap = 1'h0, force_low = 1'h0, strap = 1'h0, traffic = 1'h0;
    logic i_quiesce_grant_n, i_clock_keepalive, i_transfer_start_strobe_n, o_quiesce_request_n;
    logic o_idle, o_clocks_run, o_snoop_enable, o_quiescent, o_reduced_pinout, o_unsupported_nap;
    plph_state_t o_power_state;
    int fails = 0, comparisons = 0, cycles = 0, n;
    always #20 i_clock = ~i_clock;
    plph_handshake uut (
        .i_clock                     (i_clock),
        .i_rst                       (i_rst),
        .i_power_mgmt_bit            (i_power_mgmt_bit),
        .i_quiesce_want              (i_quiesce_want),
        .i_quiesce_grant_n           (i_quiesce_grant_n),
        .i_clock_keepalive           (i_clock_keepalive),
        .i_core_idle                 (i_core_idle),
        .i_transfer_start_strobe_n   (i_transfer_start_strobe_n),
        .i_extended_transfer_start_n (i_extended_transfer_start_n),
        .i_snoop_writeback           (i_snoop_writeback),
        .o_quiesce_request_n         (o_quiesce_request_n),
        .o_idle                      (o_idle),
        .o_clocks_run                (o_clocks_run),
        .o_snoop_enable              (o_snoop_enable),
        .o_quiescent                 (o_quiescent),
        .o_reduced_pinout            (o_reduced_pinout),
        .o_power_state               (o_power_state),
        .o_unsupported_nap           (o_unsupported_nap)
    );
    plph_sys_model sys (.i_clock, .i_rst, .i_quiesce_request_n_n(o_quiesce_request_n), .i_idle(o_idle),
        .i_go_nap(go_nap), .i_force_low(force_low), .i_strap(strap), .i_traffic(traffic),
        .o_keep(i_clock_keepalive), .o_grant_n(i_quiesce_grant_n),
        .o_start_n(i_transfer_start_strobe_n));
    task check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'h1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check
    // Step past an edge so its updates have landed
    task tick;
        @(posedge i_clock);
        #1;
    endtask : tick
    task test_done;
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task do_reset(input logic s);
        @(posedge i_clock) {i_rst, strap, i_power_mgmt_bit, force_low} <= {1'h1, s, 2'h0};
        repeat (16) @(posedge i_clock);
        i_rst <= 1'h0;
        repeat (2) tick;
        check(o_reduced_pinout === s && o_power_state === PLPH_NORMAL, "strap");
    endtask : do_reset
    task t_quiesce;
        @(posedge i_clock) i_quiesce_want <= 1'h1;
        repeat (4) tick;
        check(!o_quiesce_request_n && o_quiescent && !o_snoop_enable, "quiesce");
        @(posedge i_clock) i_quiesce_want <= 1'h0;
        repeat (3) tick;
        check(o_quiesce_request_n && !o_quiescent && o_snoop_enable, "unquiesce");
    endtask : t_quiesce
    task t_doze;
        @(posedge i_clock) {i_core_idle, i_power_mgmt_bit} <= 2'h3;
        for (n = 0; n < 20 && o_power_state !== PLPH_DOZE; n++) tick;
        check(o_power_state === PLPH_DOZE && o_idle, "doze");
        @(posedge i_clock) traffic <= 1'h1;
        for (n = 0; n < 20 && i_transfer_start_strobe_n !== 1'h0; n++) tick;
        tick;
        check(o_idle === 1'h0, "idle in start");
        @(posedge i_clock) {traffic, i_snoop_writeback} <= 2'h1;
        repeat (2) tick;
        check(o_idle === 1'h0, "idle in write-back");
        @(posedge i_clock) i_snoop_writeback <= 1'h0;
        repeat (2) tick;
        check(o_idle === 1'h1, "idle back");
        // One-cycle extended start must also count as bus activity
        @(posedge i_clock) i_extended_transfer_start_n <= 1'h0;
        @(posedge i_clock) i_extended_transfer_start_n <= 1'h1;
        #1 check(o_idle === 1'h0, "idle in extended start");
    endtask : t_doze
    task t_nap;
        @(posedge i_clock) go_nap <= 1'h1;
        for (n = 0; n < 60 && o_power_state !== PLPH_NAP; n++) tick;
        check(o_power_state === PLPH_NAP && !o_snoop_enable && !o_clocks_run, "nap");
        @(posedge i_clock) go_nap <= 1'h0;
        for (n = 0; n < 30 && i_clock_keepalive !== 1'h1; n++) tick;
        repeat (3) tick;
        check(o_clocks_run === 1'h1, "wake");
        for (n = 0; n < 30 && o_power_state !== PLPH_DOZE; n++) tick;
        check(o_power_state === PLPH_DOZE && o_snoop_enable, "redoze");
    endtask : t_nap
    task t_direct;
        do_reset(1'h0);
        @(posedge i_clock) force_low <= 1'h1;
        repeat (4) tick;
        @(posedge i_clock) i_power_mgmt_bit <= 1'h1;
        repeat (3) tick;
        check(o_power_state === PLPH_NAP && o_unsupported_nap, "direct nap");
    endtask : t_direct
    initial begin
        do_reset(1'h1);
        do_reset(1'h0);
        t_quiesce;
        t_doze;
        t_nap;
        t_direct;
        test_done;
    end
    // The run needs under two hundred cycles; this cuts a hang short
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            test_done;
        end
    end
endmodule : plph_handshake_tb
bind plph_handshake plph_handshake_asserts #(.SETTLE(SETTLE)) chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_power_mgmt_bit(i_power_mgmt_bit),
    .i_quiesce_want(i_quiesce_want), .i_quiesce_grant_n(i_quiesce_grant_n),
    .i_clock_keepalive(i_clock_keepalive), .i_core_idle(i_core_idle),
    .i_transfer_start_strobe_n(i_transfer_start_strobe_n),
    .i_extended_transfer_start_n(i_extended_transfer_start_n),
    .i_snoop_writeback(i_snoop_writeback), .o_quiesce_request_n(o_quiesce_request_n),
    .o_idle(o_idle), .o_clocks_run(o_clocks_run), .o_snoop_enable(o_snoop_enable),
    .o_quiescent(o_quiescent), .o_reduced_pinout(o_reduced_pinout),
    .o_unsupported_nap(o_unsupported_nap), .o_power_state(o_power_state)
);
